/* File: inactivity_timeout_regs.vh */
`ifndef INACTIVITY_TIMEOUT_REGS_VH
`define INACTIVITY_TIMEOUT_REGS_VH

// Register offsets from the block base address
`define OFS_TIMEOUT_PERIOD 2'h0
`define OFS_TRIGGER_MASK   2'h1
`define OFS_ALARM_STATUS   2'h2
`define OFS_RESERVED       2'h3

// Trigger mask field positions
`define MASK_BIT_KEYBOARD  0
`define MASK_BIT_MOUSE     1
`define MASK_BIT_SERIAL1   2
`define MASK_BIT_SERIAL2   3
`define MASK_FIELD_WIDTH   4

// Reset values
`define RST_TIMEOUT_PERIOD 8'h00
`define RST_TRIGGER_MASK   8'h00
`define RST_ALARM_STATUS   8'h01
`define RST_ALARM_BIT      1'b1

// Timing
`define CLOCK_HZ           40000000
`define MINUTE_SECONDS     60
// Written out as a literal: the product overflows 32-bit integer math
`define MINUTE_CYCLES      32'd2400000000

`endif

/* File: minute_prescaler.v */
`timescale 1ns/1ps
`default_nettype none

module minute_prescaler #(
   parameter [31:0] CYCLES = 32'd2400000000
) (
   input  wire ref_clk_in,
   input  wire rst_in,
   input  wire restart_in,
   output reg  tick_out
);

   reg [31:0] count;

   // Restart zeroes the count so the next tick is a full period away
   always @(posedge ref_clk_in) begin
      if (rst_in || restart_in) begin
         count    <= 32'h00000000;
         tick_out <= 1'b0;
      end else if (count == CYCLES - 32'd1) begin
         count    <= 32'h00000000;
         tick_out <= 1'b1;
      end else begin
         count    <= count + 32'h00000001;
         tick_out <= 1'b0;
      end
   end

endmodule

`default_nettype wire

/* File: inactivity_timeout_timer.v */
// Overview of operation
// - Eight-bit down counter decrements once per minute
// - Timeout spans 1 to 255 whole minutes
// - Watch keyboard, mouse, two serial IRQs
// - Mask selects which events restart countdown
// - Reset clears period, idles, alarm high
// - Nonzero period write loads and starts counting
// - Unmasked event before zero reloads the counter
// - At zero stop, alarm low, status 0
// - Any period write releases alarm, status 1
// - Writing zero deactivates the timer
// - Status bit mirrors alarm output level
// - Assigned IRQ active while status reads 0
// - Registers at offsets 0 to 2, 3 reserved
// - Mask bits 0-3 enable sources, 7-4 reserved
`timescale 1ns/1ps
`default_nettype none
`include "inactivity_timeout_regs.vh"

module inactivity_timeout_timer #(
   parameter [31:0] MINUTE_CYCLES = `MINUTE_CYCLES
) (
   input  wire       ref_clk_in,
   input  wire       rst_in,
   input  wire       reg_wr_in,
   input  wire [1:0] reg_addr_in,
   input  wire [7:0] reg_wdata_in,
   output reg  [7:0] reg_rdata_out,
   input  wire [3:0] irq_lines_in,
   input  wire       irq_assign_en_in,
   output reg        inactivity_alarm_n_out,
   output reg        alarm_irq_out,
   output reg        timer_active_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Local constants

   localparam integer NUM_SOURCES = `MASK_FIELD_WIDTH;
   localparam [7:0]   PERIOD_OFF  = 8'h00;
   localparam [1:0]   ST_IDLE     = 2'h0;
   localparam [1:0]   ST_COUNT    = 2'h1;
   localparam [1:0]   ST_EXPIRED  = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Registers and wires

   // Host-visible registers
   reg  [7:0]             timeout_period_reg;
   reg  [7:0]             trigger_mask_reg;
   reg                    alarm_status_reg;

   // Countdown state
   reg  [7:0]             countdown;
   reg  [1:0]             state;

   // Next values
   reg  [1:0]             next_state;
   reg  [7:0]             next_countdown;
   reg                    next_alarm_status;
   reg  [7:0]             next_timeout_period;
   reg  [7:0]             next_trigger_mask;
   reg  [7:0]             next_rdata;

   // Event and control path
   wire [NUM_SOURCES-1:0] line_level;
   wire [NUM_SOURCES-1:0] source_hit;
   wire                   active;
   wire                   minute_tick;
   wire                   period_wr;
   wire                   mask_wr;
   wire                   start_wr;
   wire                   trigger_hit;
   wire                   reload;
   wire                   last_minute;
   wire [7:0]             countdown_less_one;

   ////////////////////////////////////////////////////////////////////////////
   // Per-source synchronisers

   genvar src;
   generate
      for (src = 0; src < NUM_SOURCES; src = src + 1) begin : g_source
         reg stage1;
         reg stage2;
         reg stage3;

         // Lines are asynchronous, so three stages guard against metastability
         always @(posedge ref_clk_in) begin
            if (rst_in) begin
               stage1 <= 1'b0;
               stage2 <= 1'b0;
               stage3 <= 1'b0;
            end else begin
               stage1 <= irq_lines_in[src];
               stage2 <= stage1;
               stage3 <= stage2;
            end
         end

         // Stages two and three must both be high before a level counts
         assign line_level[src] = stage2 & stage3;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Per-source mask qualification

   generate
      for (src = 0; src < NUM_SOURCES; src = src + 1) begin : g_qualify
         assign source_hit[src] = line_level[src] & trigger_mask_reg[src];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Write decode and trigger qualification

   assign period_wr          = reg_wr_in && (reg_addr_in == `OFS_TIMEOUT_PERIOD);
   assign mask_wr            = reg_wr_in && (reg_addr_in == `OFS_TRIGGER_MASK);
   assign start_wr           = period_wr && (reg_wdata_in != PERIOD_OFF);
   assign active             = (state == ST_COUNT);
   assign last_minute        = (countdown <= 8'h01);
   assign countdown_less_one = countdown - 8'h01;
   // A held line keeps reloading, so a stuck IRQ counts as constant activity
   assign trigger_hit        = active && (|source_hit);
   assign reload             = start_wr || trigger_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Minute tick

   minute_prescaler #(
      .CYCLES (MINUTE_CYCLES)
   ) u_prescaler (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .restart_in (reload),
      .tick_out   (minute_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers

   // Period write also acts as the start or stop command
   always @* begin
      next_timeout_period = timeout_period_reg;
      if (period_wr) begin
         next_timeout_period = reg_wdata_in;
      end
   end

   // Reserved mask bits store zero and read back as zero
   always @* begin
      next_trigger_mask = trigger_mask_reg;
      if (mask_wr) begin
         next_trigger_mask                     = 8'h00;
         next_trigger_mask[`MASK_BIT_KEYBOARD] = reg_wdata_in[`MASK_BIT_KEYBOARD];
         next_trigger_mask[`MASK_BIT_MOUSE]    = reg_wdata_in[`MASK_BIT_MOUSE];
         next_trigger_mask[`MASK_BIT_SERIAL1]  = reg_wdata_in[`MASK_BIT_SERIAL1];
         next_trigger_mask[`MASK_BIT_SERIAL2]  = reg_wdata_in[`MASK_BIT_SERIAL2];
      end
   end

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         timeout_period_reg <= `RST_TIMEOUT_PERIOD;
      end else begin
         timeout_period_reg <= next_timeout_period;
      end
   end

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         trigger_mask_reg <= `RST_TRIGGER_MASK;
      end else begin
         trigger_mask_reg <= next_trigger_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Countdown state machine, next values

   // A period write wins over a trigger or a tick in the same cycle
   always @* begin
      next_state        = state;
      next_countdown    = countdown;
      next_alarm_status = alarm_status_reg;
      if (period_wr) begin
         next_alarm_status = 1'b1;
         next_countdown    = reg_wdata_in;
         if (start_wr) begin
            next_state = ST_COUNT;
         end else begin
            next_state = ST_IDLE;
         end
      end else begin
         case (state)
            ST_IDLE: begin
               // Parked: events and ticks are ignored here
               next_countdown = countdown;
            end
            ST_COUNT: begin
               if (trigger_hit) begin
                  next_countdown = timeout_period_reg;
               end else if (minute_tick) begin
                  if (last_minute) begin
                     next_countdown    = 8'h00;
                     next_state        = ST_EXPIRED;
                     next_alarm_status = 1'b0;
                  end else begin
                     next_countdown = countdown_less_one;
                  end
               end
            end
            ST_EXPIRED: begin
               // Stays expired until the next period write or reset
               next_alarm_status = 1'b0;
            end
            default: begin
               next_state        = ST_IDLE;
               next_countdown    = 8'h00;
               next_alarm_status = 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Countdown state machine, registers

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         state            <= ST_IDLE;
         countdown        <= 8'h00;
         alarm_status_reg <= `RST_ALARM_BIT;
      end else begin
         state            <= next_state;
         countdown        <= next_countdown;
         alarm_status_reg <= next_alarm_status;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data select

   // Offset three is reserved and reads zero
   always @* begin
      case (reg_addr_in)
         `OFS_TIMEOUT_PERIOD: begin
            next_rdata = timeout_period_reg;
         end
         `OFS_TRIGGER_MASK: begin
            next_rdata = trigger_mask_reg;
         end
         `OFS_ALARM_STATUS: begin
            next_rdata = {7'h00, alarm_status_reg};
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs

   // The pin follows the status bit one edge later, so both read alike
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         inactivity_alarm_n_out <= 1'b1;
      end else begin
         inactivity_alarm_n_out <= alarm_status_reg;
      end
   end

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         alarm_irq_out <= 1'b0;
      end else begin
         alarm_irq_out <= irq_assign_en_in && !alarm_status_reg;
      end
   end

   // Mirrors the running state for the host
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         timer_active_out <= 1'b0;
      end else begin
         timer_active_out <= active;
      end
   end

   // Read data answers the address of the previous edge
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         reg_rdata_out <= next_rdata;
      end
   end

endmodule

`default_nettype wire

/* File: timer_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_props(
   input wire       ref_clk_in,
   input wire       rst_in,
   input wire       reg_wr_in,
   input wire [1:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire [7:0] reg_rdata_out,
   input wire       inactivity_alarm_n_out,
   input wire       alarm_irq_out,
   input wire       timer_active_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   sequence s_wr;
      reg_wr_in && reg_addr_in == 2'h0;
   endsequence
   sequence s_go;
      s_wr ##0 reg_wdata_in != 8'h00;
   endsequence
   a_wr_release: assert property (s_wr |=> ##1 inactivity_alarm_n_out)
      else $error("alarm kept after write");
   a_go_active: assert property (s_go |=> ##1 timer_active_out)
      else $error("timer not started");
   a_zero_stop: assert property (s_wr ##0 reg_wdata_in == 8'h00 |=> ##1 !timer_active_out)
      else $error("timer not stopped");
   // Write releases one edge late, so the hold skips that edge
   a_alarm_hold: assert property (!inactivity_alarm_n_out && !$past(reg_wr_in && reg_addr_in == 2'h0)
      |=> !inactivity_alarm_n_out)
      else $error("alarm dropped");
   a_alarm_cause: assert property ($fell(inactivity_alarm_n_out) |-> $past(timer_active_out, 2))
      else $error("alarm while idle");
   a_irq_alarm: assert property (alarm_irq_out |-> !inactivity_alarm_n_out)
      else $error("irq without alarm");
   a_mask_read: assert property ($past(reg_addr_in) == 2'h1 |-> reg_rdata_out[7:4] == 4'h0)
      else $error("mask high bits set");
   a_status_mirror: assert property (!$past(rst_in) && $past(reg_addr_in) == 2'h2
      |-> reg_rdata_out == {7'h00, inactivity_alarm_n_out})
      else $error("status differs from alarm");
   a_reserved_zero: assert property ($past(reg_addr_in) == 2'h3 |-> reg_rdata_out == 8'h00)
      else $error("reserved read nonzero");
endmodule
`default_nettype wire

/* File: irq_source.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_source(
   input  wire       ref_clk_in,
   input  wire [3:0] req_in,
   output reg  [3:0] irq_lines_out
);
   initial irq_lines_out = 4'h0;
   // Peripherals change levels away from the sampling edge
   always @(negedge ref_clk_in) irq_lines_out <= req_in;
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam integer M = 4;
   reg clk = 0, rst = 1, wr = 0, en = 0;
   reg [1:0] a = 2'h0;
   reg [7:0] d = 8'h00;
   reg [3:0] req = 4'h0;
   wire [3:0] irq;
   wire [7:0] rd;
   wire an, aq, act;
   integer failures = 0, n_compared = 0, i;
   initial forever #12.5 clk = ~clk;
   inactivity_timeout_timer #(.MINUTE_CYCLES(M)) u_dut(.ref_clk_in(clk), .rst_in(rst),
      .reg_wr_in(wr), .reg_addr_in(a), .reg_wdata_in(d), .reg_rdata_out(rd),
      .irq_lines_in(irq), .irq_assign_en_in(en), .inactivity_alarm_n_out(an),
      .alarm_irq_out(aq), .timer_active_out(act));
   irq_source u_irq(.ref_clk_in(clk), .req_in(req), .irq_lines_out(irq));
   ////////////////////////////////////////////////////////////////
   task chk(input [7:0] s, input [7:0] e);
      n_compared = n_compared + 1;
      if (s !== e) begin
         failures = failures + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task w(input [1:0] x, input [7:0] y);
      @(negedge clk);
      wr = 1;
      a = x;
      d = y;
      @(negedge clk);
      wr = 0;
   endtask
   task r(input [1:0] x, input [7:0] e);
      @(negedge clk);
      a = x;
      @(negedge clk);
      chk(rd, e);
   endtask
   task t_reset;
      rst = 1;
      repeat (10) @(negedge clk);
      rst = 0;
      r(0, 8'h00);
      r(1, 8'h00);
      r(2, 8'h01);
      r(3, 8'h00);
      chk({7'h00, an}, 8'h01);
      chk({7'h00, act}, 8'h00);
      $display("reset done");
   endtask
   task t_expire;
      en = 1;
      w(0, 8'h02);
      i = 0;
      while (an !== 1'b0 && i < 4 * M) begin
         @(negedge clk);
         i = i + 1;
      end
      chk({7'h00, i >= 2 * M && i <= 2 * M + 3}, 8'h01);
      chk({7'h00, aq}, 8'h01);
      r(2, 8'h00);
      repeat (2 * M) @(negedge clk);
      chk({7'h00, an}, 8'h00);
      $display("expire done");
   endtask
   task t_mask;
      en = 0;
      w(1, 8'hff);
      r(1, 8'h0f);
      w(1, 8'h02);
      w(0, 8'h01);
      req = 4'h1;
      repeat (3 * M) @(negedge clk);
      chk({7'h00, an}, 8'h00);
      chk({7'h00, aq}, 8'h00);
      w(0, 8'h01);
      req = 4'h2;
      repeat (3 * M) @(negedge clk);
      chk({7'h00, an}, 8'h01);
      req = 4'h0;
      repeat (3 * M) @(negedge clk);
      chk({7'h00, an}, 8'h00);
      $display("mask done");
   endtask
   task t_stop;
      w(0, 8'hff);
      w(0, 8'h01);
      r(0, 8'h01);
      repeat (3 * M) @(negedge clk);
      chk({7'h00, an}, 8'h00);
      w(0, 8'h00);
      repeat (3 * M) @(negedge clk);
      chk({7'h00, an}, 8'h01);
      chk({7'h00, act}, 8'h00);
      $display("stop done");
   endtask
   task final_report;
      $display("compared %0d failed %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      t_reset;
      t_expire;
      t_reset;
      t_mask;
      t_stop;
      final_report;
   end
   // Hang guard, far beyond the roughly 140 cycles of the tests
   initial begin
      #100000;
      failures = failures + 1;
      final_report;
   end
endmodule
bind inactivity_timeout_timer timer_props u_props(.*);
`default_nettype wire
